// [bridge_error_status_pm_capability.sv]
// System-error cause flags and read-only power management capability header
`timescale 1ns/1ns
module bridge_error_status_pm_capability (
  input  wire logic                                     clock,
  input  wire logic                                     reset_n,
  input  wire logic                                     clockEnable,
  input  wire logic                                     cfgRead,
  input  wire logic                                     cfgWrite,
  input  wire logic [bridge_serr_pm_pkg::ADDR_W-1:0]    cfgAddr,
  input  wire logic [bridge_serr_pm_pkg::LANE_COUNT-1:0] cfgByteEnN,
  input  wire logic [bridge_serr_pm_pkg::DATA_W-1:0]    cfgWriteData,
  output logic      [bridge_serr_pm_pkg::DATA_W-1:0]    cfgReadData,
  output logic                                          cfgReadValid,
  input  wire logic [bridge_serr_pm_pkg::CAUSE_COUNT-1:0] errorEvent,
  input  wire logic [bridge_serr_pm_pkg::CAUSE_COUNT-1:0] eventDisable,
  input  wire logic                                     serrEnable,
  input  wire logic                                     hotSwapModePin,
  output logic                                          systemErrorOutN,
  output logic                                          systemErrorOe,
  output logic      [bridge_serr_pm_pkg::CAUSE_COUNT-1:0] causeFlags
);
  import bridge_serr_pm_pkg::*;

  // Dword decode, used by both the read and the write path
  function automatic logic hitsDword(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] offset);
    hitsDword = (addr[ADDR_W-1:DWORD_LSB] == offset[ADDR_W-1:DWORD_LSB]);
  endfunction : hitsDword

  // Capability header word as seen by a read of its dword
  function automatic logic [DATA_W-1:0] pmHeader(input logic hotSwap);
    logic [DATA_W-1:0] word;
    word = READ_ZERO;
    word[CAPABILITY_IDENTIFIER_FIELD_LSB +: LANE_W]          = CAPABILITY_IDENTIFIER_FIELD_VALUE;
    word[LIST_LINK_LSB +: LANE_W]       = hotSwap ? LIST_LINK_HOTSWAP
                                                  : LIST_LINK_END;
    word[WAKE_SUPPORT_LSB +: 5]         = WAKE_SUPPORT_VALUE;
    word[STATE_TWO_BIT]                 = ZERO_BIT;
    word[STATE_ONE_BIT]                 = ZERO_BIT;
    word[DEV_INIT_BIT]                  = ZERO_BIT;
    word[AUX_POWER_BIT]                 = ZERO_BIT;
    word[WAKE_CLOCK_BIT]                = ZERO_BIT;
    word[PM_VERSION_LSB +: 3]           = PM_VERSION_VALUE;
    word[PM_RSVD_LSB +: 3]              = PM_RSVD_VALUE;
    pmHeader = word;
  endfunction : pmHeader

  logic [CAUSE_COUNT-1:0] flags_q;
  logic [CAUSE_COUNT-1:0] flags_d;
  logic [CAUSE_COUNT-1:0] serrCause;
  logic [CAUSE_COUNT-1:0] clearMask;
  logic [DATA_W-1:0]      readData_d;
  logic [DATA_W-1:0]      readData_q;
  logic                   readValid_q;
  logic                   serrDrive_q;
  logic                   serrDriveN_q;
  logic                   hotSwapMeta_q;
  logic                   hotSwap_q;
  logic                   flagLaneWrite;

  // Mode strap comes from a board pin, so it is synchronised before use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hotSwapMeta_q <= 1'b0;
      hotSwap_q     <= 1'b0;
    end else if (clockEnable) begin
      hotSwapMeta_q <= hotSwapModePin;
      hotSwap_q     <= hotSwapMeta_q;
    end
  end

  // An event counts only if the bridge actually raises the error output for it
  always_comb begin
    serrCause = errorEvent & ~(eventDisable & DISABLE_BIT_MASK) & {CAUSE_COUNT{serrEnable}};
  end

  // Write-one-to-clear, only through the flag byte lane
  always_comb begin
    flagLaneWrite = cfgWrite && hitsDword(cfgAddr, SERR_STATUS_OFFSET)
                    && !cfgByteEnN[SERR_FLAG_LANE];
    clearMask     = flagLaneWrite ? cfgWriteData[SERR_FLAG_LSB +: CAUSE_COUNT]
                                  : SERR_FLAGS_RESET;
  end

  // A new cause wins over a clear landing on the same edge
  genvar gi;
  generate
    for (gi = 0; gi < CAUSE_COUNT; gi++) begin : gFlag
      always_comb begin
        flags_d[gi] = serrCause[gi] | (flags_q[gi] & ~clearMask[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= SERR_FLAGS_RESET;
    end else if (clockEnable) begin
      flags_q <= flags_d;
    end
  end

  // Open-drain error output: low one cycle per qualifying event
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serrDrive_q <= 1'b0;
      serrDriveN_q <= 1'b1;
    end else if (clockEnable) begin
      serrDrive_q <= |serrCause;
      serrDriveN_q <= ~|serrCause;
    end
  end

  // Read mux; capability dword is read-only so writes there fall away
  always_comb begin
    readData_d = READ_ZERO;
    if (hitsDword(cfgAddr, SERR_STATUS_OFFSET)) begin
      readData_d[SERR_FLAG_LSB +: CAUSE_COUNT] = flags_q;
    end else if (hitsDword(cfgAddr, PM_CAP_OFFSET)) begin
      readData_d = pmHeader(hotSwap_q);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readData_q  <= READ_ZERO;
      readValid_q <= 1'b0;
    end else if (clockEnable) begin
      readValid_q <= cfgRead;
      if (cfgRead) begin
        readData_q <= readData_d;
      end
    end
  end

  assign cfgReadData     = readData_q;
  assign cfgReadValid    = readValid_q;
  assign systemErrorOutN = serrDriveN_q;
  assign systemErrorOe   = serrDrive_q;
  assign causeFlags      = flags_q;

  // Checks
  default clocking cbCfg @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic readPm;
  logic readSt;
  assign readPm = clockEnable && cfgRead && hitsDword(cfgAddr, PM_CAP_OFFSET);
  assign readSt = clockEnable && cfgRead && hitsDword(cfgAddr, SERR_STATUS_OFFSET);
  logic readOther;
  assign readOther = clockEnable && cfgRead && !hitsDword(cfgAddr, SERR_STATUS_OFFSET)
                     && !hitsDword(cfgAddr, PM_CAP_OFFSET);

  a_addr_parity_flag: assert property (
    clockEnable && errorEvent[CAUSE_ADDR_PARITY] && serrEnable
    |=> causeFlags[CAUSE_ADDR_PARITY] && systemErrorOe)
    else $error("address parity cause not recorded");

  a_posted_parity_flag: assert property (
    clockEnable && errorEvent[CAUSE_POSTED_PARITY] && serrEnable
      && !eventDisable[CAUSE_POSTED_PARITY]
    |=> causeFlags[CAUSE_POSTED_PARITY] && !systemErrorOutN)
    else $error("posted parity cause not recorded");

  a_posted_undeliv_flag: assert property (
    clockEnable && errorEvent[CAUSE_POSTED_UNDELIVER] && serrEnable
      && !eventDisable[CAUSE_POSTED_UNDELIVER]
    |=> causeFlags[CAUSE_POSTED_UNDELIVER])
    else $error("posted undelivered cause not recorded");

  a_target_abort_flag: assert property (
    clockEnable && errorEvent[CAUSE_POSTED_TGT_ABORT] && serrEnable
      && !eventDisable[CAUSE_POSTED_TGT_ABORT]
    |=> causeFlags[CAUSE_POSTED_TGT_ABORT])
    else $error("target abort cause not recorded");

  a_master_abort_flag: assert property (
    clockEnable && errorEvent[CAUSE_POSTED_MST_ABORT] && serrEnable
      && !eventDisable[CAUSE_POSTED_MST_ABORT]
    |=> causeFlags[CAUSE_POSTED_MST_ABORT])
    else $error("master abort cause not recorded");

  a_delayed_write_flag: assert property (
    clockEnable && errorEvent[CAUSE_DELAYED_WR_UNDELV] && serrEnable
      && !eventDisable[CAUSE_DELAYED_WR_UNDELV]
    |=> causeFlags[CAUSE_DELAYED_WR_UNDELV])
    else $error("delayed write cause not recorded");

  a_delayed_read_flag: assert property (
    clockEnable && errorEvent[CAUSE_DELAYED_RD_NODATA] && serrEnable
      && !eventDisable[CAUSE_DELAYED_RD_NODATA]
    |=> causeFlags[CAUSE_DELAYED_RD_NODATA])
    else $error("delayed read cause not recorded");

  a_retry_timeout_flag: assert property (
    clockEnable && errorEvent[CAUSE_RETRY_TIMEOUT] && serrEnable
    |=> causeFlags[CAUSE_RETRY_TIMEOUT])
    else $error("retry timeout cause not recorded");

  a_flag_one_clears: assert property (
    clockEnable && flagLaneWrite
    |=> (causeFlags & $past(clearMask) & ~$past(serrCause)) == SERR_FLAGS_RESET)
    else $error("written one did not clear flag");

  a_flag_zero_holds: assert property (
    clockEnable && !flagLaneWrite
    |=> (($past(causeFlags) & ~causeFlags) == SERR_FLAGS_RESET))
    else $error("flag dropped without a clearing write");

  a_capability_identifier_field_value: assert property (
    readPm |=> cfgReadValid && cfgReadData[CAPABILITY_IDENTIFIER_FIELD_LSB +: LANE_W] == CAPABILITY_IDENTIFIER_FIELD_VALUE)
    else $error("capability identifier wrong");

  a_hotswap_link: assert property (
    readPm && hotSwap_q |=> cfgReadData[LIST_LINK_LSB +: LANE_W] == LIST_LINK_HOTSWAP)
    else $error("hot-swap list link wrong");

  a_list_end_link: assert property (
    readPm && !hotSwap_q |=> cfgReadData[LIST_LINK_LSB +: LANE_W] == LIST_LINK_END)
    else $error("list end link wrong");

  a_pm_word_value: assert property (
    readPm |=> cfgReadData[DATA_W-1:PM_VERSION_LSB] == PM_CAP_WORD_RESET)
    else $error("power capability word wrong");

  a_strap_two_stage: assert property (
    clockEnable && hotSwapModePin ##1 clockEnable && hotSwapModePin
    |=> hotSwap_q)
    else $error("mode strap not taken after two stages");

  a_serr_gated_enable: assert property (
    clockEnable && !serrEnable |=> !systemErrorOe)
    else $error("error output without enable");

  a_serr_disable_mask: assert property (
    clockEnable && ((errorEvent & ~(eventDisable & DISABLE_BIT_MASK)) == SERR_FLAGS_RESET)
    |=> !systemErrorOe && (causeFlags & ~$past(causeFlags)) == SERR_FLAGS_RESET)
    else $error("disabled event raised error output");

  a_lane_gated_write: assert property (
    clockEnable && cfgWrite && cfgByteEnN[SERR_FLAG_LANE]
    |=> (($past(causeFlags) & ~causeFlags) == SERR_FLAGS_RESET))
    else $error("write with lane disabled changed flags");

  a_status_read_data: assert property (
    readSt |=> cfgReadData[SERR_FLAG_LSB +: CAUSE_COUNT] == $past(causeFlags)
               && cfgReadData[SERR_FLAG_LSB-1:0] == 16'h0000)
    else $error("status read data wrong");

  a_read_one_cycle: assert property (
    clockEnable && cfgRead |=> cfgReadValid ##1 (!cfgReadValid || $past(cfgRead)))
    else $error("read valid not a single cycle per request");

  a_outputs_agree: assert property (
    systemErrorOe == !systemErrorOutN)
    else $error("error output and its enable disagree");

  a_set_beats_clear: assert property (
    clockEnable && flagLaneWrite
    |=> (causeFlags & $past(serrCause)) == $past(serrCause))
    else $error("clear won over a new cause");

  a_cause_drives_out: assert property (
    clockEnable && |serrCause |=> systemErrorOe && !systemErrorOutN)
    else $error("qualifying cause did not drive error output");

  a_flag_needs_cause: assert property (
    clockEnable |=> (causeFlags & ~$past(causeFlags) & ~$past(serrCause)) == SERR_FLAGS_RESET)
    else $error("flag set without a qualifying cause");

  a_no_enable_no_flag: assert property (
    clockEnable && !serrEnable |=> (causeFlags & ~$past(causeFlags)) == SERR_FLAGS_RESET)
    else $error("flag set while error output disabled");

  a_frozen_flags: assert property (
    !clockEnable |=> $stable(causeFlags) && $stable(systemErrorOe) && $stable(systemErrorOutN))
    else $error("flags or error output moved while frozen");

  a_frozen_read: assert property (
    !clockEnable |=> $stable(cfgReadData) && $stable(cfgReadValid))
    else $error("read port moved while frozen");

  a_read_data_holds: assert property (
    clockEnable && !cfgRead |=> $stable(cfgReadData))
    else $error("read data changed without a read");

  a_no_read_no_valid: assert property (
    clockEnable && !cfgRead |=> !cfgReadValid)
    else $error("read valid without a read");

  a_unmapped_read_zero: assert property (
    readOther |=> cfgReadValid && cfgReadData == READ_ZERO)
    else $error("unmapped dword did not read zero");

  a_status_upper_zero: assert property (
    readSt |=> cfgReadData[DATA_W-1:SERR_FLAG_LSB+CAUSE_COUNT] == 8'h00)
    else $error("status upper byte not zero");

  a_strap_low_stages: assert property (
    clockEnable && !hotSwapModePin ##1 clockEnable && !hotSwapModePin
    |=> !hotSwap_q)
    else $error("mode strap low not taken after two stages");

  a_state_support_zero: assert property (
    readPm |=> cfgReadData[WAKE_SUPPORT_LSB +: 5] == WAKE_SUPPORT_VALUE
               && cfgReadData[STATE_TWO_BIT] == ZERO_BIT && cfgReadData[STATE_ONE_BIT] == ZERO_BIT)
    else $error("wake or state support bit not zero");

  a_init_aux_clock_zero: assert property (
    readPm |=> cfgReadData[DEV_INIT_BIT] == ZERO_BIT && cfgReadData[AUX_POWER_BIT] == ZERO_BIT
               && cfgReadData[WAKE_CLOCK_BIT] == ZERO_BIT)
    else $error("init, aux power or wake clock bit not zero");

  a_reserved_bits_zero: assert property (
    readPm |=> cfgReadData[PM_RSVD_LSB +: 3] == PM_RSVD_VALUE)
    else $error("reserved capability bits not zero");

  c_flag_set_cleared: cover property (
    clockEnable && |serrCause ##[1:20] clockEnable && flagLaneWrite);

  c_set_clear_same: cover property (
    clockEnable && flagLaneWrite && |(serrCause & clearMask));

  c_hotswap_read: cover property (readPm && hotSwap_q);

  c_masked_event: cover property (
    clockEnable && serrEnable && |(errorEvent & eventDisable & DISABLE_BIT_MASK));

endmodule : bridge_error_status_pm_capability

// [bridge_serr_pm_pkg.sv]
// Constants for the system-error cause flags and power management capability header
package bridge_serr_pm_pkg;

  // Configuration access geometry
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LANE_COUNT = 4;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned DWORD_LSB  = 2;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] SERR_STATUS_OFFSET = 8'h68;
  localparam logic [ADDR_W-1:0] PM_CAP_OFFSET      = 8'hDC;

  // Cause flag byte placement in its dword
  localparam int unsigned       CAUSE_COUNT      = 8;
  localparam int unsigned       SERR_FLAG_LANE   = 2;
  localparam int unsigned       SERR_FLAG_LSB    = 16;
  localparam logic [7:0]        SERR_FLAGS_RESET = 8'h00;

  // Cause index inside the flag byte
  localparam int unsigned CAUSE_ADDR_PARITY       = 0;
  localparam int unsigned CAUSE_POSTED_PARITY     = 1;
  localparam int unsigned CAUSE_POSTED_UNDELIVER  = 2;
  localparam int unsigned CAUSE_POSTED_TGT_ABORT  = 3;
  localparam int unsigned CAUSE_POSTED_MST_ABORT  = 4;
  localparam int unsigned CAUSE_DELAYED_WR_UNDELV = 5;
  localparam int unsigned CAUSE_DELAYED_RD_NODATA = 6;
  localparam int unsigned CAUSE_RETRY_TIMEOUT     = 7;

  // Event disable byte has no bit for address parity or retry timeout
  localparam logic [7:0] DISABLE_BIT_MASK = 8'h7E;

  // Capability header field positions
  localparam int unsigned CAPABILITY_IDENTIFIER_FIELD_LSB       = 0;
  localparam int unsigned LIST_LINK_LSB    = 8;
  localparam int unsigned PM_VERSION_LSB   = 16;
  localparam int unsigned WAKE_CLOCK_BIT   = 19;
  localparam int unsigned AUX_POWER_BIT    = 20;
  localparam int unsigned DEV_INIT_BIT     = 21;
  localparam int unsigned PM_RSVD_LSB      = 22;
  localparam int unsigned STATE_ONE_BIT    = 25;
  localparam int unsigned STATE_TWO_BIT    = 26;
  localparam int unsigned WAKE_SUPPORT_LSB = 27;

  // Capability header values
  localparam logic [7:0]  CAPABILITY_IDENTIFIER_FIELD_VALUE       = 8'h01;
  localparam logic [7:0]  LIST_LINK_HOTSWAP  = 8'hE4;
  localparam logic [7:0]  LIST_LINK_END      = 8'h00;
  localparam logic [2:0]  PM_VERSION_VALUE   = 3'h2;
  localparam logic [4:0]  WAKE_SUPPORT_VALUE = 5'h00;
  localparam logic [2:0]  PM_RSVD_VALUE      = 3'h0;
  localparam logic        ZERO_BIT           = 1'b0;
  localparam logic [15:0] PM_CAP_WORD_RESET  = 16'h0002;

  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage : bridge_serr_pm_pkg

// [cfg_host_model.sv]
// Primary bus host model issuing configuration reads and writes
`timescale 1ns/1ns
module cfg_host_model (
  input  wire logic                                      clock,
  output logic                                           cfgRead,
  output logic                                           cfgWrite,
  output logic [bridge_serr_pm_pkg::ADDR_W-1:0]          cfgAddr,
  output logic [bridge_serr_pm_pkg::LANE_COUNT-1:0]      cfgByteEnN,
  output logic [bridge_serr_pm_pkg::DATA_W-1:0]          cfgWriteData,
  input  wire logic [bridge_serr_pm_pkg::DATA_W-1:0]     cfgReadData,
  input  wire logic                                      cfgReadValid
);
  import bridge_serr_pm_pkg::*;

  initial begin
    cfgRead      = 1'b0;
    cfgWrite     = 1'b0;
    cfgAddr      = 8'h00;
    cfgByteEnN   = 4'hF;
    cfgWriteData = 32'h0000_0000;
  end

  // Idle lines carry the inverse of the last value so a stale lane never passes for a match
  task automatic writeReg(input logic [ADDR_W-1:0] addr, input logic [LANE_COUNT-1:0] benN,
                          input logic [DATA_W-1:0] data);
    @(posedge clock);
    cfgWrite     <= 1'b1;
    cfgAddr      <= addr;
    cfgByteEnN   <= benN;
    cfgWriteData <= data;
    @(posedge clock);
    cfgWrite     <= 1'b0;
    cfgAddr      <= ~addr;
    cfgByteEnN   <= ~benN;
    cfgWriteData <= ~data;
  endtask : writeReg

  task automatic readReg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output bit ok);
    int k;
    ok   = 1'b0;
    data = '0;
    @(posedge clock);
    cfgRead    <= 1'b1;
    cfgAddr    <= addr;
    cfgByteEnN <= 4'h0;
    @(posedge clock);
    cfgRead    <= 1'b0;
    cfgAddr    <= ~addr;
    cfgByteEnN <= 4'hF;
    for (k = 0; k < 4 && !ok; k++) begin
      #2;
      if (cfgReadValid === 1'b1) begin
        ok   = 1'b1;
        data = cfgReadData;
      end else begin
        @(posedge clock);
      end
    end
  endtask : readReg
endmodule : cfg_host_model

// [tb.sv]
// Self-checking testbench for the cause flags and power capability header
`timescale 1ns/1ns
module tb;
  import bridge_serr_pm_pkg::*;

  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              clockEnable = 1'b1;
  logic              cfgRead, cfgWrite, cfgReadValid;
  logic [ADDR_W-1:0] cfgAddr;
  logic [3:0]        cfgByteEnN;
  logic [31:0]       cfgWriteData, cfgReadData;
  logic [7:0]        errorEvent = 8'h00;
  logic [7:0]        eventDisable = 8'h00;
  logic              serrEnable = 1'b0;
  logic              hotSwapModePin = 1'b0;
  logic              systemErrorOutN, systemErrorOe;
  logic [7:0]        causeFlags;
  int                n_mismatch = 0;
  int                compares = 0;

  always #4 clock = ~clock;

  bridge_error_status_pm_capability i_bridge_error_status_pm_capability (
    .clock(clock), .reset_n(reset_n), .clockEnable(clockEnable), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEnN(cfgByteEnN), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .cfgReadValid(cfgReadValid), .errorEvent(errorEvent), .eventDisable(eventDisable), .serrEnable(serrEnable),
    .hotSwapModePin(hotSwapModePin), .systemErrorOutN(systemErrorOutN), .systemErrorOe(systemErrorOe),
    .causeFlags(causeFlags));

  cfg_host_model i_cfg_host_model (
    .clock(clock), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEnN(cfgByteEnN),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid));

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic readCheck(input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    bit          ok;
    i_cfg_host_model.readReg(addr, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t: read answer never came", $time);
      results();
    end else begin
      check(d, exp);
      // Return on an edge so the caller's next drive lands there
      @(posedge clock);
    end
  endtask : readCheck

  // Drives one event cycle and judges the registered output in the cycle after it
  task automatic pulseEvent(input logic [7:0] ev, input logic [7:0] expFlags, input logic driven);
    @(posedge clock);
    errorEvent <= ev;
    @(posedge clock);
    errorEvent <= 8'h00;
    #2;
    check({30'h0, systemErrorOe, systemErrorOutN}, {30'h0, driven, ~driven});
    check({24'h0, causeFlags}, {24'h0, expFlags});
    @(posedge clock);
  endtask : pulseEvent

  task automatic resetValues();
    check({22'h0, systemErrorOe, systemErrorOutN, causeFlags}, 32'h0000_0100);
    readCheck(SERR_STATUS_OFFSET, 32'h0000_0000);
    readCheck(8'h40, 32'h0000_0000);
  endtask : resetValues

  task automatic capHeader();
    readCheck(PM_CAP_OFFSET, 32'h0002_0001);
    i_cfg_host_model.writeReg(PM_CAP_OFFSET, 4'h0, 32'hFFFF_FFFF);
    readCheck(PM_CAP_OFFSET, 32'h0002_0001);
    @(posedge clock);
    hotSwapModePin <= 1'b1;
    repeat (3) @(posedge clock);
    readCheck(PM_CAP_OFFSET, 32'h0002_E401);
    hotSwapModePin <= 1'b0;
    repeat (3) @(posedge clock);
    readCheck(PM_CAP_OFFSET, 32'h0002_0001);
  endtask : capHeader

  // Each cause sets only its own flag; clearing honours the value and the lane
  task automatic eachCause();
    logic [7:0] bitMask;
    serrEnable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bitMask = 8'h01 << i;
      pulseEvent(bitMask, bitMask, 1'b1);
      readCheck(SERR_STATUS_OFFSET, {8'h00, bitMask, 16'h0000});
      i_cfg_host_model.writeReg(SERR_STATUS_OFFSET, 4'b1011, 32'h0000_0000);
      i_cfg_host_model.writeReg(SERR_STATUS_OFFSET, 4'b0100, 32'hFFFF_FFFF);
      #2 check({24'h0, causeFlags}, {24'h0, bitMask});
      i_cfg_host_model.writeReg(SERR_STATUS_OFFSET, 4'b1011, {8'h00, bitMask, 16'h0000});
      #2 check({24'h0, causeFlags}, 32'h0000_0000);
    end
  endtask : eachCause

  task automatic gating();
    @(posedge clock);
    serrEnable <= 1'b0;
    pulseEvent(8'h08, 8'h00, 1'b0);
    serrEnable   <= 1'b1;
    eventDisable <= 8'h7E;
    pulseEvent(8'h7E, 8'h00, 1'b0);
    eventDisable <= 8'hFF;
    pulseEvent(8'h81, 8'h81, 1'b1);
    eventDisable <= 8'h00;
    clockEnable  <= 1'b0;
    pulseEvent(8'h10, 8'h81, 1'b0);
    clockEnable  <= 1'b1;
    i_cfg_host_model.writeReg(SERR_STATUS_OFFSET, 4'b1011, 32'h0081_0000);
    #2 check({24'h0, causeFlags}, 32'h0000_0000);
  endtask : gating

  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #2;
    resetValues();
    capHeader();
    eachCause();
    gating();
    results();
  end
endmodule : tb
